// >>> hdl/spc_serial_control.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bit 7 reads and writes the framing error flag when the framing select bit is set, else mode bit zero.
// - a bad stop bit sets the framing error flag and only a software write clears it.
// - the multiprocessor bit turns on multiprocessor framing and address recognition together.
// - the receive enable bit allows reception; with it clear the receiver is held off.
// - the transmitter sets the tx done flag after the last bit, only software clears it.
// - the receiver sets the rx done flag after a frame's last bit, only software clears it.
// - tx and rx done flags combine into one shared serial interrupt request.
`include "spc_map.svh"
module spc_serial_control
    import spc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // events from the shift engines (async to this clock)
    input  wire logic        tx_last_bit,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_stop_bit,
    input  wire logic        rx_ninth_in,
    input  wire logic        rx_addr_match,
    // configuration to the shift engines
    output var  logic [1:0]  mode,
    output var  logic [1:0]  baud_sel,
    output var  logic        rx_enable,
    output var  logic        multiproc_enable,
    output var  logic        tx_ninth_bit,
    // interrupts
    output var  logic        serial_irq,
    output var  logic        irq
);
    logic [7:0] serial_control;
    logic [7:0] power_control_reg;
    logic       framing_error_flag;
    logic       mode_bit_zero;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic       tx_s, rx_s, tx_q, rx_q;
    logic       stop_s, ninth_s, match_s;
    logic       tx_ev, rx_ev, rx_take, fe_ev;
    logic       wr, rd;
    logic [7:0] sc_view;
    logic [2:0] next_status;

    spc_sync u_tx (.ref_clk(ref_clk), .rst(rst), .din(tx_last_bit),  .dout(tx_s));
    spc_sync u_rx (.ref_clk(ref_clk), .rst(rst), .din(rx_frame_end), .dout(rx_s));
    // qualifiers take the same path, so they settle no later than the strobe edge
    spc_sync u_stop  (.ref_clk(ref_clk), .rst(rst), .din(rx_stop_bit),   .dout(stop_s));
    spc_sync u_ninth (.ref_clk(ref_clk), .rst(rst), .din(rx_ninth_in),   .dout(ninth_s));
    spc_sync u_match (.ref_clk(ref_clk), .rst(rst), .din(rx_addr_match), .dout(match_s));

    // rising edges of the synchronised strobes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_q <= 1'b0;
            rx_q <= 1'b0;
        end else begin
            tx_q <= tx_s;
            rx_q <= rx_s;
        end
    end

    // qualifiers must be steady before frame end or the old level is taken
    assign tx_ev = tx_s & ~tx_q;
    assign rx_ev = rx_s & ~rx_q & serial_control[`SPC_BIT_REN];
    // in multiproc mode only matched address frames complete
    assign rx_take = rx_ev & (~serial_control[`SPC_BIT_SM2] |
                     (mode == SPC_MODE_SYNC) | match_s);
    assign fe_ev = rx_ev & (mode != SPC_MODE_SYNC) & ~stop_s;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    // bit 7 shows the flag or the mode bit
    always_comb begin
        sc_view = serial_control;
        sc_view[`SPC_BIT_FE_SM0] = power_control_reg[`SPC_BIT_FSEL] ?
                                   framing_error_flag : mode_bit_zero;
    end

    // serial control register, hardware sets win over software clears
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_control <= `SPC_SERIAL_CONTROL_RST;
        end else begin
            if (wr && paddr == `SPC_SERIAL_CONTROL_ADDR) begin
                serial_control <= pwdata[7:0];
            end
            if (tx_ev) begin
                serial_control[`SPC_BIT_TI] <= 1'b1;
            end
            if (rx_take) begin
                serial_control[`SPC_BIT_RI] <= 1'b1;
                if (mode == SPC_MODE_ASYNC8 && !serial_control[`SPC_BIT_SM2]) begin
                    serial_control[`SPC_BIT_RB8] <= stop_s;
                end else if (mode[1]) begin
                    serial_control[`SPC_BIT_RB8] <= ninth_s;
                end
            end
        end
    end

    // mode bit zero and the framing flag share bit 7 but are kept apart
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_bit_zero      <= 1'b0;
            framing_error_flag <= 1'b0;
        end else begin
            if (wr && paddr == `SPC_SERIAL_CONTROL_ADDR) begin
                if (power_control_reg[`SPC_BIT_FSEL]) begin
                    framing_error_flag <= pwdata[`SPC_BIT_FE_SM0];
                end else begin
                    mode_bit_zero <= pwdata[`SPC_BIT_FE_SM0];
                end
            end
            if (fe_ev) begin
                framing_error_flag <= 1'b1;
            end
        end
    end

    // power control register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            power_control_reg <= `SPC_POWER_CONTROL_RST;
        end else if (wr && paddr == `SPC_POWER_CONTROL_ADDR) begin
            power_control_reg <= pwdata[7:0];
        end
    end

    // sticky status, read clears, new events win
    always_comb begin
        next_status = irq_status;
        if (rd && paddr == `SPC_IRQ_STATUS_ADDR) begin
            next_status = 3'h0;
        end
        if (tx_ev) begin
            next_status[`SPC_IRQ_TX] = 1'b1;
        end
        if (rx_take) begin
            next_status[`SPC_IRQ_RX] = 1'b1;
        end
        if (fe_ev) begin
            next_status[`SPC_IRQ_FE] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_mask <= `SPC_IRQ_MASK_RST;
        end else if (wr && paddr == `SPC_IRQ_MASK_ADDR) begin
            irq_mask <= pwdata[2:0];
        end
    end

    // decoded configuration outputs, registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode             <= 2'h0;
            baud_sel         <= 2'h0;
            rx_enable        <= 1'b0;
            multiproc_enable <= 1'b0;
            tx_ninth_bit     <= 1'b0;
            serial_irq       <= 1'b0;
            irq              <= 1'b0;
        end else begin
            mode <= {mode_bit_zero, serial_control[`SPC_BIT_SM1]};
            case (spc_mode_e'({mode_bit_zero, serial_control[`SPC_BIT_SM1]}))
                SPC_MODE_SYNC:   baud_sel <= SPC_BAUD_OSC12;
                SPC_MODE_FIXED9: baud_sel <= power_control_reg[`SPC_BIT_DOUBLE] ?
                                             SPC_BAUD_OSC32 : SPC_BAUD_OSC64;
                default:         baud_sel <= SPC_BAUD_TIMER;
            endcase
            rx_enable        <= serial_control[`SPC_BIT_REN];
            // no effect in mode 0
            multiproc_enable <= serial_control[`SPC_BIT_SM2] &
                                (mode_bit_zero | serial_control[`SPC_BIT_SM1]);
            tx_ninth_bit     <= serial_control[`SPC_BIT_TB8];
            serial_irq       <= serial_control[`SPC_BIT_TI] |
                                serial_control[`SPC_BIT_RI];
            irq              <= |(next_status & irq_mask);
        end
    end

    // apb: zero wait, unmapped reads zero with error
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (psel && !penable) begin
                case (paddr)
                    `SPC_SERIAL_CONTROL_ADDR: prdata <= {24'h0, sc_view};
                    `SPC_POWER_CONTROL_ADDR:  prdata <= {24'h0, power_control_reg};
                    `SPC_IRQ_STATUS_ADDR:     prdata <= {29'h0, irq_status};
                    `SPC_IRQ_MASK_ADDR:       prdata <= {29'h0, irq_mask};
                    default:                  pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/spc_map.svh
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
// register byte addresses on apb
`define SPC_SERIAL_CONTROL_ADDR 12'h098
`define SPC_POWER_CONTROL_ADDR  12'h0A0
`define SPC_IRQ_STATUS_ADDR     12'h0A4
`define SPC_IRQ_MASK_ADDR       12'h0A8
// serial_control field positions
`define SPC_BIT_FE_SM0   7
`define SPC_BIT_SM1      6
`define SPC_BIT_SM2      5
`define SPC_BIT_REN      4
`define SPC_BIT_TB8      3
`define SPC_BIT_RB8      2
`define SPC_BIT_TI       1
`define SPC_BIT_RI       0
// power_control_reg field positions
`define SPC_BIT_FSEL     6
`define SPC_BIT_DOUBLE   7
// irq status positions
`define SPC_IRQ_TX       0
`define SPC_IRQ_RX       1
`define SPC_IRQ_FE       2
// reset values
`define SPC_SERIAL_CONTROL_RST 8'h00
`define SPC_POWER_CONTROL_RST  8'h00
`define SPC_IRQ_MASK_RST       3'h0
`endif

// >>> hdl/spc_pkg.sv
package spc_pkg;
    // operating modes selected by the two mode bits
    typedef enum logic [1:0] {
        SPC_MODE_SYNC   = 2'h0,
        SPC_MODE_ASYNC8 = 2'h1,
        SPC_MODE_FIXED9 = 2'h2,
        SPC_MODE_VAR9   = 2'h3
    } spc_mode_e;
    // baud source derived from the mode
    typedef enum logic [1:0] {
        SPC_BAUD_OSC12,
        SPC_BAUD_OSC32,
        SPC_BAUD_OSC64,
        SPC_BAUD_TIMER
    } spc_baud_e;
endpackage

// >>> hdl/spc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// three stage synchroniser, a change counts once stages two and three agree
module spc_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // async in, clean out
    input  wire logic din,
    output var  logic dout
);
    logic [2:0] stage;

    // shift chain, stage 0 read only by stage 1
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], din};
        end
    end

    // hold last agreed value so a glitch between stages is ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            dout <= stage[2];
        end
    end
endmodule
`default_nettype wire

// >>> bench/spc_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module spc_engine_model (
    // clock
    input  wire logic ref_clk,
    // requests from the bench
    input  wire logic go_tx,
    input  wire logic go_rx,
    // end-of-frame levels toward the block
    output var  logic tx_last_bit,
    output var  logic rx_frame_end
);
    logic [3:0] tcnt = 4'h0;
    logic [3:0] rcnt = 4'h0;
    // held six cycles; the block's synchroniser drops only single-cycle pulses
    always_ff @(posedge ref_clk) begin
        tcnt <= go_tx ? 4'h6 : tcnt - 4'(tcnt != 4'h0);
        rcnt <= go_rx ? 4'h6 : rcnt - 4'(rcnt != 4'h0);
    end
    assign tx_last_bit  = (tcnt != 4'h0);
    assign rx_frame_end = (rcnt != 4'h0);
endmodule
`default_nettype wire

// >>> bench/spc_serial_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module spc_serial_control_assertions (
    // taps on the block's ports
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_last_bit,
    input wire logic [1:0]  mode,
    input wire logic [1:0]  baud_sel,
    input wire logic        rx_enable,
    input wire logic        multiproc_enable,
    input wire logic        tx_ninth_bit,
    input wire logic        serial_irq,
    input wire logic        irq
);
    logic       fsel_q;
    logic [2:0] mask_q;
    logic       wr;
    assign wr = psel && penable && pwrite && pready;
    // shadow of framing select and mask, seen only through bus writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fsel_q <= 1'b0;
            mask_q <= 3'h0;
        end else if (wr && paddr == 12'h0A0) begin
            fsel_q <= pwdata[6];
        end else if (wr && paddr == 12'h0A8) begin
            mask_q <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence setup_s; psel && !penable; endsequence
    sequence serial_control_wr_s; wr && paddr == 12'h098; endsequence
    AST_ANSWER: assert property (setup_s |=> pready)
        else $error("no answer in access cycle");
    AST_SLVERR: assert property (pslverr |-> pready)
        else $error("error without ready");
    // outputs follow a register write two edges later
    AST_MODE_WR: assert property (serial_control_wr_s ##0 !fsel_q |=>
        ##1 mode == $past(pwdata[7:6], 2))
        else $error("mode not written");
    AST_FE_SEL: assert property (serial_control_wr_s ##0 fsel_q |=>
        ##1 mode[1] == $past(mode[1], 2))
        else $error("mode bit zero written under framing select");
    AST_CFG_WR: assert property (serial_control_wr_s |=>
        ##1 {rx_enable, tx_ninth_bit} == $past(pwdata[4:3], 2))
        else $error("config bits not written");
    AST_MP_WR: assert property (serial_control_wr_s |=>
        ##1 multiproc_enable == ($past(pwdata[5], 2) && mode != 2'h0))
        else $error("multiprocessor enable wrong");
    AST_BAUD_SYNC: assert property ((mode == 2'h0) [*2] |-> baud_sel == 2'h0)
        else $error("mode 0 baud wrong");
    AST_BAUD_VAR: assert property (mode[0] [*2] |-> baud_sel == 2'h3)
        else $error("variable baud wrong");
    AST_TX_IRQ: assert property ($rose(tx_last_bit) |-> ##[2:10] serial_irq)
        else $error("tx event gave no request");
    AST_MASKED: assert property ((mask_q == 3'h0) [*2] |-> !irq)
        else $error("irq while fully masked");
    AST_RESET: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> !irq && !serial_irq && mode == 2'h0)
        else $error("outputs not cleared by reset");
endmodule
bind spc_serial_control spc_serial_control_assertions chk_u (.*);
`default_nettype wire

// >>> bench/spc_serial_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_map.svh"
module spc_serial_control_tb;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, v, seed = 32'h5F38EECF;
    logic        pready, pslverr, tx_last_bit, rx_frame_end, go_tx = 1'b0, go_rx = 1'b0;
    logic        rx_stop_bit = 1'b1, rx_ninth_in = 1'b0, rx_addr_match = 1'b1, pc7, se;
    logic [1:0]  mode, baud_sel;
    logic        rx_enable, multiproc_enable, tx_ninth_bit, serial_irq, irq;
    int          errors = 0, comparisons = 0, i;
    always #5 ref_clk = ~ref_clk;
    spc_serial_control dut_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_last_bit, .rx_frame_end, .rx_stop_bit,
        .rx_ninth_in, .rx_addr_match, .mode, .baud_sel, .rx_enable, .multiproc_enable,
        .tx_ninth_bit, .serial_irq, .irq);
    spc_engine_model eng_u (.ref_clk, .go_tx, .go_rx, .tx_last_bit, .rx_frame_end);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected {mode, baud source, multiproc, receive, ninth tx}
    function automatic logic [31:0] cfg(input logic [7:0] s, input logic p7);
        logic [1:0] b;
        b = (s[7:6] == 2'h0) ? 2'h0 : (s[7:6] == 2'h2) ? (p7 ? 2'h1 : 2'h2) : 2'h3;
        // multiprocessor bit has no effect in mode 0
        return {25'h0, s[7:6], b, s[5] & (s[7:6] != 2'h0), s[4:3]};
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer; an idle cycle first keeps psel from being driven twice at one edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin errors++; print_verdict(); end
        r = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic event_wait(input logic tx);
        int n;
        n = 0;
        if (tx) go_tx <= 1'b1; else go_rx <= 1'b1;
        @(posedge ref_clk);
        go_tx <= 1'b0; go_rx <= 1'b0;
        while (serial_irq !== 1'b1 && n < 50) begin @(posedge ref_clk); n++; end
        if (serial_irq !== 1'b1) begin errors++; print_verdict(); end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
        chk("serial_control_reset", r, 32'h0);
        chk("serial_control_no_err", 32'(se), 32'h0);
        apb(0, 12'h0FC, 0);
        chk("unmapped", r, 32'h0);
        chk("unmapped_err", 32'(se), 32'h1);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            v = rnd();
            pc7 = v[8];
            v = {24'h0, i[1:0], v[5:3], 3'h0};
            apb(1, `SPC_POWER_CONTROL_ADDR, {24'h0, pc7, 7'h0});
            apb(1, `SPC_SERIAL_CONTROL_ADDR, v);
            apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
            #1;
            chk("serial_control_rw", r & 32'hF8, v);
            chk("cfg_out", {25'h0, mode, baud_sel, multiproc_enable, rx_enable, tx_ninth_bit}, cfg(v[7:0], pc7));
        end
        $display("test config done");
        apb(1, `SPC_IRQ_MASK_ADDR, 32'h1);
        apb(1, `SPC_SERIAL_CONTROL_ADDR, 32'h0);
        event_wait(1'b1);
        chk("irq_tx", 32'(irq), 32'h1);
        apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
        chk("tx_flag", r, 32'h2);
        apb(0, `SPC_IRQ_STATUS_ADDR, 0);
        chk("status", r, 32'h1);
        apb(1, `SPC_SERIAL_CONTROL_ADDR, 32'h0);
        apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
        #1;
        chk("tx_clear", {r[30:0], serial_irq}, 32'h0);
        chk("irq_clear", 32'(irq), 32'h0);
        $display("test tx done");
        // mode 2, receiver on, then framing select; bad stop, ninth bit high
        apb(1, `SPC_SERIAL_CONTROL_ADDR, 32'h90);
        apb(1, `SPC_POWER_CONTROL_ADDR, 32'h40);
        rx_stop_bit <= 1'b0; rx_ninth_in <= 1'b1;
        event_wait(1'b0);
        apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
        chk("rx_flags", r, 32'h95);
        rx_stop_bit <= 1'b1;
        apb(1, `SPC_SERIAL_CONTROL_ADDR, 32'h10);
        apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
        chk("fe_clear", r & 32'h81, 32'h0);
        chk("mode_kept", 32'(mode), 32'h2);
        // receiver off: a frame end with a bad stop bit must leave no trace
        apb(1, `SPC_SERIAL_CONTROL_ADDR, 32'h0);
        rx_stop_bit <= 1'b0;
        go_rx <= 1'b1;
        @(posedge ref_clk);
        go_rx <= 1'b0;
        repeat (30) @(posedge ref_clk);
        apb(0, `SPC_SERIAL_CONTROL_ADDR, 0);
        chk("rx_off", r & 32'hFB, 32'h0);
        $display("test rx done");
        print_verdict();
    end
endmodule
`default_nettype wire
